// >>> add_exec_asserts.sv
// Purpose: Port timing checks for the add-group block
// Assumes: One clock, synchronous active-low reset
// Notes: Bus checks assume a master that offers address and data together
`timescale 1ns/100ps
module add_exec_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic illegal_instr_pulse
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("Write response dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("Read data not held");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("Read address taken while busy");
    property p_b_rise; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
    a_b_rise: assert property (p_b_rise) else $error("Write response late");
    property p_r_rise; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_rise: assert property (p_r_rise) else $error("Read response late");
    property p_slverr; s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000; endproperty
    a_slverr: assert property (p_slverr) else $error("Error read returned data");
    property p_ill_pulse; illegal_instr_pulse |=> !illegal_instr_pulse; endproperty
    a_ill_pulse: assert property (p_ill_pulse) else $error("Illegal pulse too long");
    property p_ill_cause; illegal_instr_pulse |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2); endproperty
    a_ill_cause: assert property (p_ill_cause) else $error("Illegal pulse without go");
endmodule : add_exec_asserts

bind add_family_execute add_exec_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .illegal_instr_pulse(illegal_instr_pulse));

// >>> add_exec_cfg.svh
// Purpose: Constants for the add-group decode and execute block
// Assumes: Bit 0 is the most significant bit of the instruction word
// Notes: Register offsets are byte addresses on the AXI4-Lite slave
// Overview of operation
// - Words are 32 bits; opcode in bits 0:5
// - Bad defined field raises illegal-instruction exception
// - Nonzero reserved bits execute undefined, no exception
// - Special register number swaps split field halves
// - Device-control register number swaps halves too
// - Time-base register number swaps halves too
// - Extended 266 adds sources, carry unchanged
// - Extended 10 adds and sets carry
// - Extended 138 adds sources plus carry
// - Overflow-enable updates overflow; record updates field zero
// - Opcode 14 adds immediate, zero when source 0
// - Opcode 12 adds immediate and updates carry
// - Opcode 13 as 12, always records
// - Opcode 15 adds shifted immediate, zero source special
`ifndef ADD_EXEC_CFG_SVH
`define ADD_EXEC_CFG_SVH
`define OP_EXT 6'h1F
`define OP_ADDIC 6'h0C
`define OP_ADDIC_REC 6'h0D
`define OP_ADDI 6'h0E
`define OP_ADDIS 6'h0F
`define XO_ADD 9'h10A
`define XO_ADDC 9'h00A
`define XO_ADDE 9'h08A
`define XO_MFSPR 10'h153
`define XO_MTSPR 10'h1D3
`define XO_MFDCR 10'h143
`define XO_MTDCR 10'h1C3
`define XO_MFTB 10'h173
`define REG_INSTR 8'h00
`define REG_CTRL 8'h04
`define REG_STATUS 8'h08
`define REG_RESULT 8'h0C
`define REG_SPLIT 8'h10
`define REG_GPR_BASE 8'h80
`define CTRL_GO 0
`define CTRL_CLR_SO 1
`define ST_ILLEGAL 0
`define ST_INVALID 1
`define ST_WROTE 2
`define ST_CA 4
`define ST_OV 5
`define ST_SO 6
`define ST_CR0_LSB 8
`define ST_SPLIT_KIND_LSB 12
`endif

// >>> add_exec_pkg.sv
// Purpose: Types for the add-group decode and execute block
// Assumes: Nothing beyond the cfg header
// Notes: Types only
package add_exec_pkg;
    typedef enum logic [1:0] {
        SPLIT_NONE = 2'b00,
        SPLIT_SPR = 2'b01,
        SPLIT_DCR = 2'b10,
        SPLIT_TBR = 2'b11
    } split_kind_t;
    typedef enum logic [3:0] {
        ADD_NONE = 4'b0000,
        ADD_RR = 4'b0001,
        ADD_RRC = 4'b0010,
        ADD_RRE = 4'b0011,
        ADD_IMM = 4'b0100,
        ADD_IMMC = 4'b0101,
        ADD_IMMCR = 4'b0110,
        ADD_IMMS = 4'b0111
    } add_op_t;
endpackage : add_exec_pkg

// >>> add_family_execute.sv
// Purpose: Decode and execute the fixed-point add group, AXI4-Lite controlled
// Assumes: Software loads operands and instruction word, then pulses go
// Notes: Execution completes in the cycle after go; one instruction at a time
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "add_exec_cfg.svh"
module add_family_execute (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic illegal_instr_pulse,
    output logic [9:0] special_reg_number,
    output add_exec_pkg::split_kind_t split_kind
);
    import add_exec_pkg::*;

    logic [31:0] instr_reg;
    logic [31:0] gpr_reg [0:31];
    logic [31:0] result_reg;
    logic carry_flag_reg;
    logic overflow_flag_reg;
    logic summary_ovf_reg;
    logic [3:0] condition_field_zero_reg;
    logic illegal_reg;
    logic invalid_reg;
    logic wrote_reg;
    logic go_reg;
    logic [9:0] split_num_reg;
    split_kind_t split_kind_reg;

    // Write channel: address and data may arrive in either order
    logic aw_held_reg;
    logic [7:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_reg || aw_fire;
    wire w_have = w_held_reg || w_fire;
    wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    wire wr_do = aw_have && w_have && !bvalid_reg;
    wire wr_is_gpr = wr_addr[7];
    wire wr_is_instr = wr_addr == `REG_INSTR;
    wire wr_is_ctrl = wr_addr == `REG_CTRL;
    wire wr_ok = wr_is_gpr || wr_is_instr || wr_is_ctrl;
    wire [4:0] wr_gpr_idx = wr_addr[6:2];
    wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_go = wr_do && wr_is_ctrl && wr_strb[0] && wr_data[`CTRL_GO];
    wire wr_clr_so = wr_do && wr_is_ctrl && wr_strb[0] && wr_data[`CTRL_CLR_SO];

    // Field extraction, bit 0 is the MSB of the word
    wire [5:0] primary_opcode = instr_reg[31:26];
    wire [4:0] dest_reg_field = instr_reg[25:21];
    wire [4:0] src_a_reg_field = instr_reg[20:16];
    wire [4:0] src_b_reg_field = instr_reg[15:11];
    wire overflow_enable = instr_reg[10];
    wire [8:0] ext_opcode9 = instr_reg[9:1];
    wire [9:0] ext_opcode10 = instr_reg[10:1];
    wire record_bit = instr_reg[0];
    wire [15:0] signed_immediate16 = instr_reg[15:0];
    wire [9:0] split_raw = instr_reg[20:11];

    wire is_ext = primary_opcode == `OP_EXT;
    wire is_add = is_ext && ext_opcode9 == `XO_ADD;
    wire is_addc = is_ext && ext_opcode9 == `XO_ADDC;
    wire is_adde = is_ext && ext_opcode9 == `XO_ADDE;
    wire is_rr = is_add || is_addc || is_adde;
    wire is_spr = is_ext && (ext_opcode10 == `XO_MFSPR || ext_opcode10 == `XO_MTSPR);
    wire is_dcr = is_ext && (ext_opcode10 == `XO_MFDCR || ext_opcode10 == `XO_MTDCR);
    wire is_tbr = is_ext && ext_opcode10 == `XO_MFTB;
    wire is_addi = primary_opcode == `OP_ADDI;
    wire is_addic = primary_opcode == `OP_ADDIC;
    wire is_addic_rec = primary_opcode == `OP_ADDIC_REC;
    wire is_addis = primary_opcode == `OP_ADDIS;
    wire is_known = is_rr || is_spr || is_dcr || is_tbr || is_addi || is_addic
        || is_addic_rec || is_addis;
    // Any word outside the supported opcode set has a wrong defined field
    wire illegal_now = !is_known;
    // Split-field moves keep bit 31 reserved; flagged but still executed
    wire invalid_now = (is_spr || is_dcr || is_tbr) && record_bit;

    wire [9:0] swapped_number;
    split_field_swap swap_inst (
        .split_field(split_raw),
        .reg_number(swapped_number)
    );
    wire split_kind_t kind_now = split_kind_t'(is_spr ? SPLIT_SPR : is_dcr ? SPLIT_DCR
        : is_tbr ? SPLIT_TBR : SPLIT_NONE);

    // Operand selection
    wire [31:0] reg_a = gpr_reg[src_a_reg_field];
    wire [31:0] reg_b = gpr_reg[src_b_reg_field];
    wire [31:0] imm_sext = {{16{signed_immediate16[15]}}, signed_immediate16};
    wire [31:0] imm_shift = {signed_immediate16, 16'h0000};
    wire a_zero_ok = (is_addi || is_addis) && src_a_reg_field == 5'h00;
    wire [31:0] op_a = a_zero_ok ? 32'h0000_0000 : reg_a;
    wire [31:0] op_b = is_rr ? reg_b : is_addis ? imm_shift : imm_sext;
    wire carry_in = is_adde ? carry_flag_reg : 1'b0;
    wire [32:0] sum_full = {1'b0, op_a} + {1'b0, op_b} + {32'h0000_0000, carry_in};
    wire [31:0] sum = sum_full[31:0];
    wire carry_out = sum_full[32];
    wire signed_ovf = (op_a[31] == op_b[31]) && (sum[31] != op_a[31]);

    wire updates_carry = is_addc || is_adde || is_addic || is_addic_rec;
    wire updates_ovf = is_rr && overflow_enable;
    wire records = (is_rr && record_bit) || is_addic_rec;
    wire writes_dest = is_rr || is_addi || is_addic || is_addic_rec || is_addis;
    wire so_next = updates_ovf ? (summary_ovf_reg || signed_ovf) : summary_ovf_reg;
    // Less-than, greater-than, equal, then summary copy
    wire [3:0] cr0_next = {sum[31], !sum[31] && sum != 32'h0000_0000,
        sum == 32'h0000_0000, so_next};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b0;
        end else begin
            if (aw_fire && !(w_have)) aw_held_reg <= 1'b1;
            if (w_fire && !(aw_have)) w_held_reg <= 1'b1;
            if (wr_do) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bresp_reg <= 2'b00;
        end else begin
            if (aw_fire) aw_addr_reg <= s_axi_awaddr;
            if (w_fire) w_data_reg <= s_axi_wdata;
            if (w_fire) w_strb_reg <= s_axi_wstrb;
            if (wr_do) bresp_reg <= wr_ok ? 2'b00 : 2'b10;
        end
    end

    // Register file write; sized 32 words, so it is an array
    always_ff @(posedge aclk) begin
        if (wr_do && wr_is_gpr) begin
            gpr_reg[wr_gpr_idx] <= (gpr_reg[wr_gpr_idx] & ~wr_mask) | (wr_data & wr_mask);
        end else if (go_reg && writes_dest) begin
            gpr_reg[dest_reg_field] <= sum;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_reg <= 32'h0000_0000;
            go_reg <= 1'b0;
        end else begin
            if (wr_do && wr_is_instr) instr_reg <= (instr_reg & ~wr_mask) | (wr_data & wr_mask);
            go_reg <= wr_go;
        end
    end

    // Execute one cycle after go, so the instruction word is stable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_reg <= 32'h0000_0000;
            carry_flag_reg <= 1'b0;
            overflow_flag_reg <= 1'b0;
            condition_field_zero_reg <= 4'h0;
            illegal_reg <= 1'b0;
            invalid_reg <= 1'b0;
            wrote_reg <= 1'b0;
            split_num_reg <= 10'h000;
            split_kind_reg <= SPLIT_NONE;
        end else if (go_reg) begin
            illegal_reg <= illegal_now;
            invalid_reg <= invalid_now;
            split_kind_reg <= kind_now;
            split_num_reg <= swapped_number;
            wrote_reg <= writes_dest;
            if (writes_dest) result_reg <= sum;
            if (updates_carry) carry_flag_reg <= carry_out;
            if (updates_ovf) overflow_flag_reg <= signed_ovf;
            if (records) condition_field_zero_reg <= cr0_next;
        end
    end

    // Sticky summary: a setting overflow wins over a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            summary_ovf_reg <= 1'b0;
        end else if (go_reg && updates_ovf && signed_ovf) begin
            summary_ovf_reg <= 1'b1;
        end else if (wr_clr_so) begin
            summary_ovf_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            illegal_instr_pulse <= 1'b0;
        end else begin
            illegal_instr_pulse <= go_reg && illegal_now;
        end
    end

    assign special_reg_number = split_num_reg;
    assign split_kind = split_kind_reg;

    wire [31:0] status_word = {16'h0000, 2'b00, split_kind_reg, condition_field_zero_reg,
        1'b0, summary_ovf_reg, overflow_flag_reg, carry_flag_reg,
        1'b0, wrote_reg, invalid_reg, illegal_reg};
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_is_gpr = s_axi_araddr[7];
    wire [31:0] rd_value;
    wire rd_ok;
    assign rd_ok = rd_is_gpr || s_axi_araddr == `REG_INSTR || s_axi_araddr == `REG_CTRL
        || s_axi_araddr == `REG_STATUS || s_axi_araddr == `REG_RESULT
        || s_axi_araddr == `REG_SPLIT;
    assign rd_value = rd_is_gpr ? gpr_reg[s_axi_araddr[6:2]]
        : s_axi_araddr == `REG_INSTR ? instr_reg
        : s_axi_araddr == `REG_STATUS ? status_word
        : s_axi_araddr == `REG_RESULT ? result_reg
        : s_axi_araddr == `REG_SPLIT ? {22'h00_0000, split_num_reg}
        : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'b00;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= rd_ok ? 2'b00 : 2'b10;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule : add_family_execute

// >>> add_family_execute_test.sv
// Purpose: Self-checking bench for the add-group block
// Assumes: Execution lands before the next bus read starts
// Notes: Flags are modelled here and compared through status reads
`timescale 1ns/100ps
`include "add_exec_cfg.svh"
module add_family_execute_test;
    import add_exec_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed = 32'h0000_FD44;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic hung, ill, ca = 1'b0, ov = 1'b0, so = 1'b0, ill_e, inv_e, wr_e;
    logic [1:0] bresp, rresp, kind_e;
    logic [3:0] cr = 4'h0;
    logic [9:0] num;
    split_kind_t kind;
    logic [65:0] expq[$];
    logic [65:0] cur;
    logic [31:0] g[4];
    int mismatches = 0;
    int checks_done = 0;
    int ill_seen = 0;
    localparam logic [5:0] OPS[7] = '{`OP_EXT, `OP_EXT, `OP_EXT, `OP_ADDI, `OP_ADDIC,
        `OP_ADDIC_REC, `OP_ADDIS};
    localparam logic [8:0] XOS[3] = '{`XO_ADD, `XO_ADDC, `XO_ADDE};
    localparam logic [9:0] MVS[5] = '{`XO_MFSPR, `XO_MTSPR, `XO_MFDCR, `XO_MTDCR, `XO_MFTB};
    localparam logic [1:0] MVK[5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    initial begin
        forever #5 aclk = ~aclk;
    end
    add_family_execute i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .illegal_instr_pulse(ill), .special_reg_number(num), .split_kind(kind));
    axi_lite_master i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
        .rready(rready), .hung(hung));
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task test_done();
        $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task cmp_val(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checks_done++;
        if ((got & m) !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got & m, exp);
        end
    endtask : cmp_val
    always @(posedge aclk) begin
        if (hung) begin
            mismatches++;
            test_done();
        end else begin
            if (ill) ill_seen++;
            if (rvalid && rready && expq.size() > 0) begin
                cur = expq.pop_front();
                cmp_val(rdata, cur[31:0], cur[63:32]);
                cmp_val({30'h0, rresp}, {30'h0, cur[65:64]}, 32'h0000_0003);
            end
        end
    end
    task expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                   input logic [1:0] r);
        expq.push_back({r, m, e});
        i_host.rd(a);
    endtask : expect_rd
    task check_status();
        expect_rd(`REG_STATUS, 32'h0000_3F77,
            {18'h0, kind_e, cr, 1'b0, so, ov, ca, 1'b0, wr_e, inv_e, ill_e}, 2'b00);
    endtask : check_status
    task exec_check(input logic [31:0] ins);
        i_host.wr(`REG_INSTR, ins);
        i_host.wr(`REG_CTRL, 32'h0000_0001);
        check_status();
        cmp_val({22'h0, num}, {22'h0, ins[15:11], ins[20:16]}, 32'h0000_03FF);
        cmp_val({30'h0, kind}, {30'h0, kind_e}, 32'h0000_0003);
    endtask : exec_check
    task run_add(input int k, input logic [4:0] ra, input logic [15:0] f, input logic oe,
                 input logic rc);
        logic [5:0] op;
        logic [31:0] a, b;
        logic [32:0] s;
        op = OPS[k];
        a = (ra == 5'd0 && (op == `OP_ADDI || op == `OP_ADDIS)) ? 32'h0000_0000
            : g[ra];
        b = (op == `OP_EXT) ? g[f[1:0]] : (op == `OP_ADDIS) ? {f, 16'h0000} : {{16{f[15]}}, f};
        s = {1'b0, a} + {1'b0, b} + {32'h0, (k == 2) ? ca : 1'b0};
        if (k == 1 || k == 2 || k == 4 || k == 5) ca = s[32];
        if (op == `OP_EXT && oe) begin
            ov = (a[31] == b[31]) && (s[31] != a[31]);
            so = so | ov;
        end
        if ((op == `OP_EXT && rc) || k == 5) begin
            cr = {s[31], !s[31] && s[31:0] != 0, s[31:0] == 0, so};
        end
        g[3] = s[31:0];
        {wr_e, ill_e, inv_e, kind_e} = 5'h10;
        exec_check(k < 3 ? {op, 5'd3, ra, f[4:0], oe, XOS[k % 3], rc} : {op, 5'd3, ra, f});
        expect_rd(`REG_GPR_BASE + 8'h0C, 32'hFFFF_FFFF, g[3], 2'b00);
        expect_rd(`REG_RESULT, 32'hFFFF_FFFF, g[3], 2'b00);
    endtask : run_add
    initial begin
        logic [31:0] r;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int n = 0; n < 12; n++) begin
            for (int j = 0; j < 3; j++) begin
                // Early rounds use extreme operands to force carry and overflow
                g[j] = (n < 4) ? {~n[0], 31'h7FFF_FFFF} : xs();
                i_host.wr(`REG_GPR_BASE + 8'(4 * j), g[j]);
            end
            for (int k = 0; k < 7; k++) begin
                r = xs();
                run_add(k, (r[17:16] == 2'b11) ? 5'd0 : {3'b000, r[17:16]},
                    (k < 3) ? {15'h0000, r[0]} + 16'h0001 : r[15:0], r[20], r[21]);
            end
        end
        for (int j = 0; j < 5; j++) begin
            r = xs();
            {wr_e, ill_e, inv_e, kind_e} = {2'b00, j[0], MVK[j]};
            exec_check({`OP_EXT, 5'd4, r[9:0], MVS[j], j[0]});
        end
        {wr_e, ill_e, inv_e, kind_e} = 5'h08;
        exec_check({6'h07, r[25:0]});
        exec_check({`OP_EXT, 15'h0C22, 1'b0, 9'h10B, 1'b0});
        i_host.wr(`REG_CTRL, 32'h0000_0002);
        so = 1'b0;
        check_status();
        expect_rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, 2'b10);
        repeat (4) @(posedge aclk);
        // Only the two illegal words may raise the exception pulse
        cmp_val(32'(ill_seen), 32'h0000_0002, 32'hFFFF_FFFF);
        test_done();
    end
endmodule : add_family_execute_test

// >>> axi_lite_master.sv
// Purpose: Bus master standing in for the fetch side
// Assumes: Tasks entered right after a clock edge
// Notes: Response ready rises with the request and stays up until the answer
`timescale 1ns/100ps
module axi_lite_master (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready,
    output logic hung
);
    initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, hung} = '0;
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        for (n = 0; n < 50 && !(bvalid && bready); n++) begin
            @(posedge aclk);
            // Released lines show a changed value so stale reuse is caught
            if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
            if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~d};
        end
        bready <= 1'b0;
        if (n == 50) hung <= 1'b1;
    endtask : wr
    task rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (n = 0; n < 50 && !(rvalid && rready); n++) begin
            @(posedge aclk);
            if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
        end
        rready <= 1'b0;
        if (n == 50) hung <= 1'b1;
    endtask : rd
endmodule : axi_lite_master

// >>> split_field_swap.sv
// Purpose: Rebuild a 10-bit register number from a split field
// Assumes: Field bit 0 is the leftmost (most significant) bit
// Notes: Same swap serves all three register spaces
`timescale 1ns/100ps
module split_field_swap (
    input wire logic [9:0] split_field,
    output logic [9:0] reg_number
);
    // Encoded 0:4 become number 5:9; encoded 5:9 become number 0:4
    assign reg_number = {split_field[4:0], split_field[9:5]};
endmodule : split_field_swap
